// ==== host_ctrl_model.sv ====
// Host controller model driving link clock and commands
`timescale 1ns/1ps
module host_ctrl_model (
  // Link to the device
  output logic linkClk,
  output logic rdCmd,
  output logic wrCmd,
  output logic burstSel,
  output logic [1:0] bankGroup
);
  int rl = 11;
  int wl = 9;
  int wtrLong = 4;
  int wtrShort = 2;
  logic onFly = 1'b0;
  logic chopFixed = 1'b0;
  int riseCnt = 0;
  int cmdRise = -100;
  logic lastWr = 1'b0;
  logic [1:0] lastBg = 2'h0;
  int lastRdBeats = 8;
  int lastWrBeats = 8;
  initial begin
    linkClk = 1'b0;
    rdCmd = 1'b0;
    wrCmd = 1'b0;
    burstSel = 1'b0;
    bankGroup = 2'h0;
  end
  // Runs free: the device needs it to lock
  always #80 linkClk = ~linkClk;
  always @(posedge linkClk) riseCnt <= riseCnt + 1;
  // Write preamble fixed at one clock
  function automatic int minGap(input logic nextWr, input logic [1:0] bg);
    if (!lastWr && nextWr) return rl - wl + lastRdBeats / 2 + 1 + 1;
    if (lastWr && !nextWr) return wl + lastWrBeats / 2 + ((bg == lastBg) ? wtrLong : wtrShort);
    return 4;
  endfunction : minGap
  // A positive gap overrides the spacing, to break it or to pin it at the minimum
  task automatic send(input logic isWr, input logic sel, input logic [1:0] bg, input int gap);
    int need;
    need = (gap > 0) ? gap : minGap(isWr, bg);
    @(negedge linkClk);
    while (riseCnt + 1 - cmdRise < need) @(negedge linkClk);
    rdCmd <= !isWr;
    wrCmd <= isWr;
    burstSel <= sel;
    bankGroup <= bg;
    cmdRise = riseCnt + 1;
    lastWr = isWr;
    lastBg = bg;
    lastRdBeats = (chopFixed || (onFly && !sel)) ? 4 : 8;
    lastWrBeats = chopFixed ? 4 : 8;
    @(negedge linkClk);
    rdCmd <= 1'b0;
    wrCmd <= 1'b0;
    burstSel <= ~sel;
    bankGroup <= ~bg;
  endtask : send
endmodule : host_ctrl_model

// ==== read_write_turnaround_spacing.sv ====
// DRAM read strobe and data launch with APB control and turnaround monitor
`timescale 1ns/1ps
// What this block does
// R1: Read-to-write gap covers latencies, burst, preamble
// R2: Write-to-read same group uses long delay
// R3: Write-to-read other group uses short delay
// R4: Read burst counts eight or four beats
// R5: Write burst counts eight unless fixed chop
// R6: Fixed or on-the-fly high select gives eight
// R7: Strobe timing only while DLL locked
// R8: Data launched on both strobe edges
// R9: Strobe preamble low, released high after postamble
// R10: On-the-fly select low chops to four beats
// R11: Turnaround minimum rounded up to whole clocks
module read_write_turnaround_spacing #(
  parameter int DQ_W = 8,
  parameter int PIPE_D = 32
) (
  // System clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // APB slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Link inputs from the controller
  input wire logic linkClk,
  input wire logic rdCmd,
  input wire logic wrCmd,
  input wire logic burstSel,
  input wire logic [1:0] bankGroup,
  // Strobe and data pins
  output logic dqsOut,
  output logic dqsOe,
  output logic [DQ_W-1:0] dqOut,
  output logic dqOe
);
  import turnaround_pkg::*;

  // Configuration and status
  logic [1:0] burstMode_q;
  logic dllEnable_q;
  logic writePreamble2_q;
  logic [4:0] casReadLatency_q;
  logic [4:0] casWriteLatency_q;
  logic [3:0] wtrLong_q;
  logic [3:0] wtrShort_q;
  logic r2wFlag_q;
  logic w2rFlag_q;
  logic [DQ_W-1:0] beatMem_q [BEATS_MAX];
  // Link sampling
  logic [5:0] syncA_q;
  logic [5:0] syncB_q;
  logic linkPrev_q;
  logic linkRise;
  logic linkFall;
  logic rdSeen;
  logic wrSeen;
  logic rdBurst8;
  // DLL lock
  logic [7:0] lockCnt_q;
  logic dllLocked_q;
  // Read pipeline and sequencer
  logic [PIPE_D-1:0] rdPipe_q;
  logic [PIPE_D-1:0] blPipe_q;
  logic [PIPE_D-1:0] rdPipeNext;
  logic [PIPE_D-1:0] blPipeNext;
  logic hitPre;
  logic hitStart;
  rd_state_t state_q;
  logic [2:0] beatIdx_q;
  logic [2:0] lastBeat_q;
  // APB
  logic apbAccess;
  logic apbWrite;
  logic [31:0] readValue;
  logic readErr;
  logic [7:0] beatOffset;
  logic r2wPulse;
  logic w2rPulse;

  // Only the second stage is read; link clock rate is far below clk
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      syncA_q <= 6'h00;
      syncB_q <= 6'h00;
      linkPrev_q <= 1'b0;
    end else begin
      syncA_q <= {bankGroup, burstSel, wrCmd, rdCmd, linkClk};
      syncB_q <= syncA_q;
      linkPrev_q <= syncB_q[0];
    end
  end

  always_comb begin
    linkRise = syncB_q[0] && !linkPrev_q;
    linkFall = !syncB_q[0] && linkPrev_q;
    rdSeen = linkRise && syncB_q[1];
    wrSeen = linkRise && syncB_q[2];
    // Chopped four beats for fixed chop, select low on the fly, or the unused mode value 3
    rdBurst8 = (burstMode_q == BURST_FIXED8) || ((burstMode_q == BURST_ON_FLY) && syncB_q[3]); // [R6] [R10]
    if (burstMode_q == BURST_ON_FLY && !syncB_q[3]) begin
      rdBurst8 = 1'b0; // [R10]
    end
    rdPipeNext = {rdPipe_q[PIPE_D-2:0], rdSeen && dllLocked_q}; // [R7]
    blPipeNext = {blPipe_q[PIPE_D-2:0], rdBurst8};
    hitPre = (casReadLatency_q != 5'h00) && rdPipeNext[casReadLatency_q - 5'h01];
    hitStart = rdPipeNext[casReadLatency_q];
  end

  // Lock counts link clocks after enable; disable drops lock at once
  always_ff @(posedge clk) begin
    if (sys_rst || !dllEnable_q) begin
      lockCnt_q <= 8'h00;
      dllLocked_q <= 1'b0;
    end else if (linkRise && !dllLocked_q) begin
      lockCnt_q <= lockCnt_q + 8'h01;
      dllLocked_q <= (lockCnt_q + 8'h01 >= DLL_LOCK_EDGES); // [R7]
    end
  end

  // Command history in link clocks since issue
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdPipe_q <= '0;
      blPipe_q <= '0;
    end else if (linkRise) begin
      rdPipe_q <= rdPipeNext;
      blPipe_q <= blPipeNext;
    end
  end

  // Strobe sequencer; every link edge is one beat
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
      dqsOut <= 1'b1;
      dqsOe <= 1'b0;
      dqOut <= '0;
      dqOe <= 1'b0;
      beatIdx_q <= 3'h0;
      lastBeat_q <= 3'h7;
    end else if (!dllLocked_q) begin
      // Losing lock aborts any burst and releases the pins
      state_q <= ST_IDLE;
      dqsOut <= 1'b1;
      dqsOe <= 1'b0;
      dqOe <= 1'b0;
    end else if (linkRise || linkFall) begin
      case (state_q)
        ST_IDLE: begin
          if (linkRise && hitPre) begin
            state_q <= ST_PRE;
            dqsOe <= 1'b1; // [R9]
            dqsOut <= 1'b0; // [R9]
          end
        end
        ST_PRE: begin
          if (linkRise && hitStart) begin
            state_q <= ST_BURST;
            dqsOut <= 1'b1; // [R8]
            dqOut <= beatMem_q[0];
            dqOe <= 1'b1;
            beatIdx_q <= 3'h0;
            lastBeat_q <= blPipeNext[casReadLatency_q] ? 3'h7 : 3'h3; // [R6] [R10]
          end
        end
        ST_BURST: begin
          if (beatIdx_q != lastBeat_q) begin
            dqsOut <= !dqsOut; // [R8]
            dqOut <= beatMem_q[beatIdx_q + 3'h1]; // [R8]
            beatIdx_q <= beatIdx_q + 3'h1;
          end else if (linkRise && hitStart) begin
            // Back-to-back read continues without a new preamble
            dqsOut <= 1'b1; // [R8]
            dqOut <= beatMem_q[0];
            beatIdx_q <= 3'h0;
            lastBeat_q <= blPipeNext[casReadLatency_q] ? 3'h7 : 3'h3; // [R6] [R10]
          end else begin
            state_q <= ST_IDLE;
            dqsOut <= 1'b1; // [R9]
            dqsOe <= 1'b0; // [R9]
            dqOe <= 1'b0;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  turnaround_checker u_checker (
    .clk(clk),
    .sys_rst(sys_rst),
    .linkRise(linkRise),
    .rdSeen(rdSeen),
    .wrSeen(wrSeen),
    .bankGroup(syncB_q[5:4]),
    .rdBurst8(rdBurst8),
    .casReadLatency(casReadLatency_q),
    .casWriteLatency(casWriteLatency_q),
    .writeToReadLongDelay(wtrLong_q),
    .writeToReadShortDelay(wtrShort_q),
    .writePreamble2(writePreamble2_q),
    .fixedChop(burstMode_q == BURST_FIXED4),
    .rdToWrViolation(r2wPulse),
    .wrToRdViolation(w2rPulse)
  );

  // APB: one wait state, write lands on the pready edge
  always_comb begin
    apbAccess = psel && penable && !pready;
    apbWrite = psel && penable && pready && pwrite;
    readValue = 32'h0;
    readErr = 1'b0;
    // Beat index counts from the first beat word, not from address zero
    beatOffset = paddr - BEAT_BASE_OFFSET;
    if (paddr == CTRL_OFFSET) begin
      readValue[CTRL_BURST_LSB +: 2] = burstMode_q;
      readValue[CTRL_DLL_EN_BIT] = dllEnable_q;
      readValue[CTRL_WPRE2_BIT] = writePreamble2_q;
    end else if (paddr == LATENCY_OFFSET) begin
      readValue[LAT_RD_LSB +: 5] = casReadLatency_q;
      readValue[LAT_WR_LSB +: 5] = casWriteLatency_q;
      readValue[LAT_WTRL_LSB +: 4] = wtrLong_q;
      readValue[LAT_WTRS_LSB +: 4] = wtrShort_q;
    end else if (paddr == STATUS_OFFSET) begin
      readValue[STAT_LOCK_BIT] = dllLocked_q;
      readValue[STAT_ACTIVE_BIT] = (state_q != ST_IDLE);
      readValue[STAT_R2W_BIT] = r2wFlag_q;
      readValue[STAT_W2R_BIT] = w2rFlag_q;
    end else if (paddr >= BEAT_BASE_OFFSET && paddr <= BEAT_LAST_OFFSET && paddr[1:0] == 2'h0) begin
      readValue[DQ_W-1:0] = beatMem_q[beatOffset[4:2]];
    end else begin
      readErr = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready <= apbAccess;
      prdata <= (apbAccess && !pwrite) ? readValue : 32'h0;
      pslverr <= apbAccess && readErr;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      burstMode_q <= BURST_RESET;
      dllEnable_q <= 1'b0;
      writePreamble2_q <= 1'b0;
      casReadLatency_q <= RD_LAT_RESET;
      casWriteLatency_q <= WR_LAT_RESET;
      wtrLong_q <= WTRL_RESET;
      wtrShort_q <= WTRS_RESET;
    end else if (apbWrite && paddr == CTRL_OFFSET) begin
      burstMode_q <= pwdata[CTRL_BURST_LSB +: 2];
      dllEnable_q <= pwdata[CTRL_DLL_EN_BIT];
      writePreamble2_q <= pwdata[CTRL_WPRE2_BIT];
    end else if (apbWrite && paddr == LATENCY_OFFSET) begin
      casReadLatency_q <= pwdata[LAT_RD_LSB +: 5];
      casWriteLatency_q <= pwdata[LAT_WR_LSB +: 5];
      wtrLong_q <= pwdata[LAT_WTRL_LSB +: 4];
      wtrShort_q <= pwdata[LAT_WTRS_LSB +: 4];
    end
  end

  // Sticky flags; a new violation wins over a write-one clear
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      r2wFlag_q <= 1'b0;
      w2rFlag_q <= 1'b0;
    end else begin
      r2wFlag_q <= r2wPulse || (r2wFlag_q && !(apbWrite && paddr == STATUS_OFFSET && pwdata[STAT_R2W_BIT])); // [R1]
      w2rFlag_q <= w2rPulse || (w2rFlag_q && !(apbWrite && paddr == STATUS_OFFSET && pwdata[STAT_W2R_BIT])); // [R2] [R3]
    end
  end

  // Beat pattern store, one word per beat
  for (genvar i = 0; i < BEATS_MAX; i++) begin : g_beat
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        beatMem_q[i] <= '0;
      end else if (apbWrite && paddr == BEAT_BASE_OFFSET + 8'(4 * i)) begin
        beatMem_q[i] <= pwdata[DQ_W-1:0];
      end
    end
  end
endmodule : read_write_turnaround_spacing

// ==== read_write_turnaround_spacing_tb.sv ====
// Self-checking bench for the read strobe and turnaround block
`timescale 1ns/1ps
`define CHECK(a, e, m) begin n_compared++; if ((a) !== (e)) begin fail_count++; $display("CHECK FAILED %0t %s", $time, m); end end
module read_write_turnaround_spacing_tb;
  import turnaround_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rdVal;
  logic pready, pslverr, rdErr;
  logic linkClk, rdCmd, wrCmd, burstSel, dqsOut, dqsOe, dqOe;
  logic [1:0] bankGroup;
  logic [7:0] dqOut;
  int fail_count = 0;
  int n_compared = 0;
  always #4 clk = ~clk;

  read_write_turnaround_spacing u_read_write_turnaround_spacing (.clk(clk), .sys_rst(sys_rst), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .linkClk(linkClk), .rdCmd(rdCmd), .wrCmd(wrCmd), .burstSel(burstSel),
    .bankGroup(bankGroup), .dqsOut(dqsOut), .dqsOe(dqsOe), .dqOut(dqOut), .dqOe(dqOe));
  host_ctrl_model u_host_ctrl_model (.linkClk(linkClk), .rdCmd(rdCmd), .wrCmd(wrCmd), .burstSel(burstSel),
    .bankGroup(bankGroup));

  task automatic conclude();
    $display("Mismatches %0d, comparisons %0d", fail_count, n_compared);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : conclude

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int t;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge clk);
      t++;
    end while (pready !== 1'b1 && t < 20);
    rdVal = prdata;
    rdErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      fail_count++;
      conclude();
    end
  endtask : apb

  task automatic regDefaults();
    apb(1'b0, LATENCY_OFFSET, 32'h0);
    `CHECK(rdVal, {8'h0, WTRS_RESET, WTRL_RESET, 3'h0, WR_LAT_RESET, 3'h0, RD_LAT_RESET}, "latency reset")
    apb(1'b0, STATUS_OFFSET, 32'h0);
    `CHECK(rdVal, 32'h0, "status reset")
    apb(1'b1, 8'h30, 32'hffffffff);
    apb(1'b0, 8'h30, 32'h0);
    `CHECK({rdErr, rdVal}, {1'b1, 32'h0}, "unmapped read")
    for (int i = 0; i < BEATS_MAX; i++) begin
      apb(1'b1, BEAT_BASE_OFFSET + 8'(4 * i), {24'h0, 8'ha0 + 8'(i)});
    end
    apb(1'b0, BEAT_LAST_OFFSET, 32'h0);
    `CHECK(rdVal, 32'h000000a7, "beat readback")
  endtask : regDefaults

  // Reads before lock would be dropped
  task automatic dllLock();
    int t;
    u_host_ctrl_model.send(1'b0, 1'b1, 2'h0, 0);
    t = 0;
    repeat (300) begin
      @(negedge clk);
      if (dqOe !== 1'b0) t++;
    end
    `CHECK(t, 0, "read dropped while unlocked")
    apb(1'b1, CTRL_OFFSET, 32'h4);
    t = 0;
    do begin
      apb(1'b0, STATUS_OFFSET, 32'h0);
      t++;
    end while (rdVal[STAT_LOCK_BIT] !== 1'b1 && t < 200);
    `CHECK(rdVal[STAT_LOCK_BIT], 1'b1, "dll lock")
  endtask : dllLock

  task automatic burstModes();
    logic [1:0] modes [4] = '{BURST_FIXED8, BURST_ON_FLY, BURST_ON_FLY, BURST_FIXED4};
    logic sels [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
    int lens [4] = '{8, 8, 4, 4};
    int t, n;
    logic prevDqs;
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, CTRL_OFFSET, {30'h1, modes[m]});
      u_host_ctrl_model.onFly = (modes[m] == BURST_ON_FLY);
      u_host_ctrl_model.chopFixed = (modes[m] == BURST_FIXED4);
      u_host_ctrl_model.send(1'b0, sels[m], 2'h1, 0);
      t = 0;
      n = 0;
      prevDqs = 1'b0;
      while (dqOe !== 1'b1 && t < 600) begin
        @(negedge clk);
        t++;
      end
      while (dqOe === 1'b1 && t < 800) begin
        if (dqsOut !== prevDqs) begin
          `CHECK(dqOut, 8'ha0 + 8'(n), "beat data")
          `CHECK(dqsOe, 1'b1, "strobe driven")
          n++;
        end
        prevDqs = dqsOut;
        @(negedge clk);
        t++;
      end
      `CHECK(n, lens[m], "beat count")
      `CHECK({dqsOe, dqsOut}, 2'b01, "strobe parked high")
    end
  endtask : burstModes

  task automatic statusBit(input int b, input logic e);
    apb(1'b0, STATUS_OFFSET, 32'h0);
    `CHECK(rdVal[b], e, "violation flag")
    apb(1'b1, STATUS_OFFSET, 32'hc);
  endtask : statusBit

  // Gaps one below the minimum: 7 for read to write, 16 same group write to read
  task automatic turnaround();
    apb(1'b1, CTRL_OFFSET, 32'h4);
    apb(1'b1, STATUS_OFFSET, 32'hc);
    u_host_ctrl_model.onFly = 1'b0;
    u_host_ctrl_model.chopFixed = 1'b0;
    u_host_ctrl_model.send(1'b0, 1'b1, 2'h0, 0);
    u_host_ctrl_model.send(1'b1, 1'b1, 2'h0, 7);
    statusBit(STAT_R2W_BIT, 1'b1);
    u_host_ctrl_model.send(1'b0, 1'b1, 2'h0, 0);
    u_host_ctrl_model.send(1'b1, 1'b1, 2'h0, 0);
    statusBit(STAT_R2W_BIT, 1'b0);
    u_host_ctrl_model.send(1'b0, 1'b1, 2'h0, 16);
    statusBit(STAT_W2R_BIT, 1'b1);
    u_host_ctrl_model.send(1'b1, 1'b1, 2'h0, 0);
    u_host_ctrl_model.send(1'b0, 1'b1, 2'h3, 15);
    statusBit(STAT_W2R_BIT, 1'b0);
    apb(1'b1, CTRL_OFFSET, 32'h6);
    u_host_ctrl_model.chopFixed = 1'b1;
    u_host_ctrl_model.send(1'b1, 1'b1, 2'h0, 0);
    u_host_ctrl_model.send(1'b0, 1'b1, 2'h0, 15);
    statusBit(STAT_W2R_BIT, 1'b0);
    u_host_ctrl_model.send(1'b1, 1'b1, 2'h0, 6);
    statusBit(STAT_R2W_BIT, 1'b0);
  endtask : turnaround

  initial begin
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    regDefaults();
    dllLock();
    burstModes();
    turnaround();
    conclude();
  end

  initial begin
    repeat (60000) @(posedge clk);
    fail_count++;
    conclude();
  end
endmodule : read_write_turnaround_spacing_tb

// ==== spacing_checker.sv ====
// Assertions on the APB answer and the read strobe pins
`timescale 1ns/1ps
module spacing_checker #(
  parameter int DQ_W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Strobe and data
  input wire logic dqsOut,
  input wire logic dqsOe,
  input wire logic [DQ_W-1:0] dqOut,
  input wire logic dqOe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  ready_pulse_a: assert property (pready |=> !pready) else $error("pready held past one cycle");
  apb_answer_a: assert property (psel && penable && !pready |=> pready) else $error("APB access not answered");
  err_with_ready_a: assert property (pslverr |-> pready) else $error("pslverr outside ready cycle");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0) else $error("prdata nonzero while idle");
  strobe_park_a: assert property (!dqsOe |-> dqsOut) else $error("undriven strobe not high");
  preamble_low_a: assert property ($rose(dqsOe) |-> !dqsOut [*8]) else $error("preamble not low");
  first_beat_a: assert property ($rose(dqOe) |-> dqsOut && $past(dqsOe) && !$past(dqsOut))
    else $error("first beat without preamble");
  data_under_strobe_a: assert property (dqOe |-> dqsOe) else $error("data driven without strobe");
  beat_on_edge_a: assert property (dqOe && $past(dqOe) && $changed(dqOut) |-> $changed(dqsOut))
    else $error("beat changed off a strobe edge");
  joint_release_a: assert property ($fell(dqsOe) |-> !dqOe && dqsOut) else $error("release not joint");
endmodule : spacing_checker

bind read_write_turnaround_spacing spacing_checker #(.DQ_W(DQ_W)) u_spacing_checker (.clk(clk), .sys_rst(sys_rst),
  .psel(psel), .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr), .dqsOut(dqsOut),
  .dqsOe(dqsOe), .dqOut(dqOut), .dqOe(dqOe));

// ==== turnaround_checker.sv ====
// Read/write turnaround spacing monitor in link clock units
`timescale 1ns/1ps
module turnaround_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Commands seen at a link clock rising edge
  input wire logic linkRise,
  input wire logic rdSeen,
  input wire logic wrSeen,
  input wire logic [1:0] bankGroup,
  input wire logic rdBurst8,
  // Configuration
  input wire logic [4:0] casReadLatency,
  input wire logic [4:0] casWriteLatency,
  input wire logic [3:0] writeToReadLongDelay,
  input wire logic [3:0] writeToReadShortDelay,
  input wire logic writePreamble2,
  input wire logic fixedChop,
  // One-cycle violation pulses
  output logic rdToWrViolation,
  output logic wrToRdViolation
);
  import turnaround_pkg::*;

  logic [7:0] sinceRd_q;
  logic [7:0] sinceWr_q;
  logic [1:0] lastWrGroup_q;
  logic lastRd8_q;
  logic seenRd_q;
  logic seenWr_q;
  logic [7:0] rdToWrMin;
  logic [7:0] wrToRdMin;
  logic [3:0] rdBeats;
  logic [3:0] wrBeats;

  // Latencies are already whole link clocks, so rounding up is exact [R11]
  always_comb begin
    rdBeats = lastRd8_q ? BURST_LEN8 : BURST_LEN4; // [R4]
    wrBeats = fixedChop ? BURST_LEN4 : BURST_LEN8; // [R5]
    rdToWrMin = 8'(casReadLatency) + 8'(rdBeats >> 1) + 8'h01 + (writePreamble2 ? 8'h02 : 8'h01)
      - 8'(casWriteLatency); // [R1]
    // Clamp a wrapped result when write latency exceeds the rest
    if (8'(casWriteLatency) > 8'(casReadLatency) + 8'(rdBeats >> 1) + (writePreamble2 ? 8'h03 : 8'h02)) begin
      rdToWrMin = 8'h00;
    end
    wrToRdMin = 8'(casWriteLatency) + 8'(wrBeats >> 1)
      + ((bankGroup == lastWrGroup_q) ? 8'(writeToReadLongDelay) : 8'(writeToReadShortDelay)); // [R2] [R3]
  end

  // Saturating distance counters
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sinceRd_q <= 8'hff;
      sinceWr_q <= 8'hff;
      lastWrGroup_q <= 2'h0;
      lastRd8_q <= 1'b1;
      seenRd_q <= 1'b0;
      seenWr_q <= 1'b0;
    end else if (linkRise) begin
      sinceRd_q <= rdSeen ? 8'h00 : ((sinceRd_q == 8'hff) ? sinceRd_q : sinceRd_q + 8'h01);
      sinceWr_q <= wrSeen ? 8'h00 : ((sinceWr_q == 8'hff) ? sinceWr_q : sinceWr_q + 8'h01);
      if (rdSeen) begin
        lastRd8_q <= rdBurst8;
        seenRd_q <= 1'b1;
      end
      if (wrSeen) begin
        lastWrGroup_q <= bankGroup;
        seenWr_q <= 1'b1;
      end
    end
  end

  // Distance counts edges since the earlier command, so compare one above
  // Widened so a saturated count cannot wrap to zero
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdToWrViolation <= 1'b0;
      wrToRdViolation <= 1'b0;
    end else begin
      rdToWrViolation <= linkRise && wrSeen && seenRd_q
        && ({1'b0, sinceRd_q} + 9'h001 < {1'b0, rdToWrMin}); // [R1]
      wrToRdViolation <= linkRise && rdSeen && seenWr_q
        && ({1'b0, sinceWr_q} + 9'h001 < {1'b0, wrToRdMin}); // [R2] [R3]
    end
  end
endmodule : turnaround_checker

// ==== turnaround_pkg.sv ====
// Shared constants and types for the read strobe and turnaround block
package turnaround_pkg;
  // Register byte offsets
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] LATENCY_OFFSET = 8'h04;
  localparam logic [7:0] STATUS_OFFSET = 8'h08;
  localparam logic [7:0] BEAT_BASE_OFFSET = 8'h10;
  localparam logic [7:0] BEAT_LAST_OFFSET = 8'h2c;
  localparam int BEATS_MAX = 8;
  // Control fields
  localparam int CTRL_BURST_LSB = 0;
  localparam int CTRL_DLL_EN_BIT = 2;
  localparam int CTRL_WPRE2_BIT = 3;
  // Latency fields
  localparam int LAT_RD_LSB = 0;
  localparam int LAT_WR_LSB = 8;
  localparam int LAT_WTRL_LSB = 16;
  localparam int LAT_WTRS_LSB = 20;
  // Status fields
  localparam int STAT_LOCK_BIT = 0;
  localparam int STAT_ACTIVE_BIT = 1;
  localparam int STAT_R2W_BIT = 2;
  localparam int STAT_W2R_BIT = 3;
  // Burst field of mode_register_zero
  localparam logic [1:0] BURST_FIXED8 = 2'h0;
  localparam logic [1:0] BURST_ON_FLY = 2'h1;
  localparam logic [1:0] BURST_FIXED4 = 2'h2;
  localparam logic [3:0] BURST_LEN8 = 4'h8;
  localparam logic [3:0] BURST_LEN4 = 4'h4;
  // Reset values
  localparam logic [1:0] BURST_RESET = 2'h0;
  localparam logic [4:0] RD_LAT_RESET = 5'h0b;
  localparam logic [4:0] WR_LAT_RESET = 5'h09;
  localparam logic [3:0] WTRL_RESET = 4'h4;
  localparam logic [3:0] WTRS_RESET = 4'h2;
  // Link clocks from DLL enable to lock
  localparam logic [7:0] DLL_LOCK_EDGES = 8'h10;
  // Read strobe sequencer
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PRE = 2'b01,
    ST_BURST = 2'b11
  } rd_state_t;
endpackage : turnaround_pkg
